// ==== rtl/clock_gate_defs.svh ====
// Constants for the peripheral clock gate and serial prescale select block
// Summary of operation
// - Each clock gate bit except unused bit 1 drives one peripheral clock (bit 7 RTC, 6 DAC, 5 ADC, 4 I2C, 0 timer).
// - A serial unit whose enable is 0 has its clock stopped, is held in reset, and takes no writes.
// - A disabled serial unit ignores control register writes and reads back only defaults.
// - Input switch, noise filter and port registers stay reachable whatever the unit enable.
// - An enabled serial unit gets its clock and its registers can be read and written.
// - Reset clears the clock gate register, which takes bit-wide and byte-wide writes.
// - The 16-bit select gives each unit two shared clocks, bits 7 to 4 and bits 3 to 0.
// - The select takes 16-bit writes, and its low byte alone takes byte-wide writes.
// - Reset clears the select register to zero.
`ifndef CLOCK_GATE_DEFS_SVH
`define CLOCK_GATE_DEFS_SVH

`define GATE_ADDR 20'hf00f0
`define SEL0_ADDR 20'hf0126
`define SEL1_ADDR 20'hf0166
`define GATE_RESET 8'h00
`define SEL_RESET 16'h0000
`define GATE_BIT_TIMER 3'h0
`define GATE_BIT_UNUSED 3'h1
`define GATE_BIT_UNIT0 3'h2
`define GATE_BIT_UNIT1 3'h3
`define GATE_BIT_I2C 3'h4
`define GATE_BIT_ADC 3'h5
`define GATE_BIT_DAC 3'h6
`define GATE_BIT_RTC 3'h7
`define SEL_A_LSB 0
`define SEL_B_LSB 4
`define PRESCALE_WIDTH 12
`define PRESCALE_MAX_CODE 4'hb

`endif

// ==== rtl/clock_gate_pkg.sv ====
// Types shared by the clock gate block
package clock_gate_pkg;
   typedef enum logic [1:0] {ACC_BIT, ACC_BYTE, ACC_WORD} access_size_t;
endpackage : clock_gate_pkg

// ==== rtl/glitch_free_gate.sv ====
// Glitch-free clock gate cell for one peripheral clock
`timescale 1ns/1ps
module glitch_free_gate (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic enable,
   output logic gated_clk
);
   logic en_low_reg;
   logic en_low_next;

   // Enable is resampled while the clock is low
   always_comb begin
      en_low_next = reset ? 1'b0 : enable;
   end

   // Falling-edge capture keeps the gate steady through every high phase
   always_ff @(negedge sys_clk) begin
      en_low_reg <= en_low_next;
   end

   // Clock passes only with a whole high phase
   assign gated_clk = sys_clk & en_low_reg;
endmodule : glitch_free_gate

// ==== rtl/serial_unit_clock_gate_select.sv ====
// Peripheral clock gate register and serial unit prescale select registers
`timescale 1ns/1ps
`include "clock_gate_defs.svh"
module serial_unit_clock_gate_select
   import clock_gate_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [19:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   input wire access_size_t bus_size,
   input wire logic [2:0] bus_bit,
   output logic [15:0] bus_rdata,
   output logic [7:0] periph_clk,
   output logic [7:0] peripheral_clock_gate,
   output logic [1:0] serial_unit_clock_on,
   output logic [1:0] serial_unit_reset,
   output logic [1:0] serial_sfr_write_ok,
   output logic [1:0] unit_op_clock_a,
   output logic [1:0] unit_op_clock_b
);
   logic [7:0] gate_reg;
   logic [7:0] gate_next;
   logic [1:0][15:0] sel_reg;
   logic [1:0][15:0] sel_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic [`PRESCALE_WIDTH-1:0] cnt_reg;
   logic [`PRESCALE_WIDTH-1:0] cnt_next;
   logic [3:0] tick_reg;
   logic [3:0] tick_next;
   logic [1:0] unit_on;
   logic gate_hit;
   logic [1:0] sel_hit;

   // Divider tick: code k up to 11 fires once every 2^k cycles; codes above 11 never fire
   function automatic logic code_tick(input logic [3:0] code,
                                      input logic [`PRESCALE_WIDTH-1:0] cnt);
      logic [`PRESCALE_WIDTH-1:0] mask;
      mask = '0;
      for (int i = 0; i < `PRESCALE_WIDTH; i++) begin
         if (i < int'(code)) begin
            mask[i] = 1'b1;
         end
      end
      code_tick = (code <= `PRESCALE_MAX_CODE) && ((cnt & mask) == mask);
   endfunction : code_tick

   // Address decode
   assign gate_hit = (bus_addr == `GATE_ADDR);
   assign sel_hit[0] = (bus_addr == `SEL0_ADDR);
   assign sel_hit[1] = (bus_addr == `SEL1_ADDR);
   assign unit_on[0] = gate_reg[`GATE_BIT_UNIT0];
   assign unit_on[1] = gate_reg[`GATE_BIT_UNIT1];

   // Clock gate register: bit and byte writes, bit 1 forced low
   always_comb begin
      gate_next = gate_reg;
      if (bus_write && gate_hit) begin
         unique case (bus_size)
            ACC_BIT: gate_next[bus_bit] = bus_wdata[0];
            ACC_BYTE: gate_next = bus_wdata[7:0];
            ACC_WORD: gate_next = gate_reg;
         endcase
      end
      gate_next[`GATE_BIT_UNUSED] = 1'b0;
      if (reset) begin
         gate_next = `GATE_RESET;
      end
   end

   always_ff @(posedge sys_clk) begin
      gate_reg <= gate_next;
   end

   // Prescale select per unit, held at default while the unit is off
   generate
      for (genvar u = 0; u < 2; u++) begin : g_unit
         always_comb begin
            sel_next[u] = sel_reg[u];
            if (reset || !unit_on[u]) begin
               sel_next[u] = `SEL_RESET;
            end else if (bus_write && sel_hit[u]) begin
               unique case (bus_size)
                  ACC_WORD: sel_next[u] = bus_wdata;
                  ACC_BYTE: sel_next[u] = {sel_reg[u][15:8], bus_wdata[7:0]};
                  ACC_BIT: sel_next[u] = sel_reg[u];
               endcase
            end
         end

         always_ff @(posedge sys_clk) begin
            sel_reg[u] <= sel_next[u];
         end

         // Two shared operating clocks per unit
         assign tick_next[2*u] = !reset && unit_on[u] &&
            code_tick(sel_reg[u][`SEL_A_LSB+3:`SEL_A_LSB], cnt_reg);
         assign tick_next[2*u+1] = !reset && unit_on[u] &&
            code_tick(sel_reg[u][`SEL_B_LSB+3:`SEL_B_LSB], cnt_reg);
         assign unit_op_clock_a[u] = tick_reg[2*u];
         assign unit_op_clock_b[u] = tick_reg[2*u+1];
      end
   endgenerate

   // Free-running prescaler and tick registers
   always_comb begin
      cnt_next = reset ? '0 : cnt_reg + 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
   end

   // Registered read data; disabled units read their default
   always_comb begin
      rdata_next = 16'h0000;
      if (!reset && bus_read) begin
         if (gate_hit) begin
            rdata_next = {8'h00, gate_reg};
         end else if (sel_hit[0]) begin
            rdata_next = unit_on[0] ? sel_reg[0] : `SEL_RESET;
         end else if (sel_hit[1]) begin
            rdata_next = unit_on[1] ? sel_reg[1] : `SEL_RESET;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      rdata_reg <= rdata_next;
   end

   // Gated peripheral clocks; the unused position stays low
   generate
      for (genvar b = 0; b < 8; b++) begin : g_gate
         if (b == 1) begin : g_unused
            assign periph_clk[b] = 1'b0;
         end else begin : g_cell
            glitch_free_gate u_gate (
               .sys_clk(sys_clk),
               .reset(reset),
               .enable(gate_reg[b]),
               .gated_clk(periph_clk[b])
            );
         end
      end
   endgenerate

   // Serial unit controls; exempt port, filter and switch registers do not use these
   assign bus_rdata = rdata_reg;
   assign peripheral_clock_gate = gate_reg;
   assign serial_unit_clock_on = unit_on;
   assign serial_unit_reset = ~unit_on;
   assign serial_sfr_write_ok = unit_on;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   chk_unused_bit_low: assert property (gate_reg[1] == 1'b0)
      else $error("unused gate bit reads one");
   chk_gate_reset_zero: assert property (disable iff (1'b0) $past(reset) |-> gate_reg == 8'h00)
      else $error("gate register not cleared by reset");
   chk_sel_reset_zero: assert property (disable iff (1'b0)
      $past(reset) |-> sel_reg[0] == 16'h0000 && sel_reg[1] == 16'h0000)
      else $error("select register not cleared by reset");
   chk_gate_byte_write: assert property (bus_write && gate_hit && bus_size == ACC_BYTE
      |=> gate_reg == {$past(bus_wdata[7:2]), 1'b0, $past(bus_wdata[0])})
      else $error("gate byte write not taken");
   chk_off_unit_held: assert property (!unit_on[0] |=> sel_reg[0] == 16'h0000)
      else $error("disabled unit select not at default");
   chk_word_write: assert property (unit_on[0] && bus_write && sel_hit[0] &&
      bus_size == ACC_WORD && gate_next[2] |=> sel_reg[0] == $past(bus_wdata))
      else $error("select word write lost");
   chk_byte_alias: assert property (unit_on[1] && bus_write && sel_hit[1] &&
      bus_size == ACC_BYTE && gate_next[3]
      |=> sel_reg[1] == {$past(sel_reg[1][15:8]), $past(bus_wdata[7:0])})
      else $error("select low byte write wrong");
   chk_read_default: assert property (bus_read && sel_hit[0] && !unit_on[0]
      |=> bus_rdata == 16'h0000)
      else $error("disabled unit read not default");
   chk_disable_resets: assert property (bus_write && gate_hit && bus_size == ACC_BYTE &&
      !bus_wdata[2] |=> serial_unit_reset[0] ##0 !serial_sfr_write_ok[0])
      else $error("disabled unit not held in reset");
   chk_reserved_quiet: assert property (sel_reg[0][3:0] > 4'hb |=> !unit_op_clock_a[0])
      else $error("reserved code produced a tick");
   chk_code_zero_runs: assert property (unit_on[0] && sel_reg[0][7:4] == 4'h0
      |=> unit_op_clock_b[0])
      else $error("undivided clock missing");

   cov_unit0_on: cover property (!unit_on[0] ##1 unit_on[0]);
   cov_word_write: cover property (unit_on[1] && bus_write && sel_hit[1] && bus_size == ACC_WORD);
   cov_default_read: cover property (bus_read && sel_hit[1] && !unit_on[1]);
   cov_tick_b: cover property (unit_op_clock_b[1]);
endmodule : serial_unit_clock_gate_select

// ==== testbench/serial_unit_clock_gate_select_tb.sv ====
// Self-checking testbench for the clock gate and prescale select block
`timescale 1ns/1ps
`include "clock_gate_defs.svh"
module serial_unit_clock_gate_select_tb
   import clock_gate_pkg::*;
;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [19:0] bus_addr = 20'h00000;
   logic [15:0] bus_wdata = 16'h0000;
   logic bus_write = 1'b0;
   logic bus_read = 1'b0;
   access_size_t bus_size = ACC_BYTE;
   logic [2:0] bus_bit = 3'h0;
   logic [15:0] bus_rdata;
   logic [7:0] periph_clk, peripheral_clock_gate;
   logic [1:0] serial_unit_clock_on, serial_unit_reset, serial_sfr_write_ok;
   logic [1:0] unit_op_clock_a, unit_op_clock_b;
   int n_errors = 0;
   int checks_done = 0;
   int e7 = 0, e4 = 0, e1 = 0;

   serial_unit_clock_gate_select uut (.sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .bus_size(bus_size),
      .bus_bit(bus_bit), .bus_rdata(bus_rdata), .periph_clk(periph_clk),
      .peripheral_clock_gate(peripheral_clock_gate), .serial_unit_clock_on(serial_unit_clock_on),
      .serial_unit_reset(serial_unit_reset), .serial_sfr_write_ok(serial_sfr_write_ok),
      .unit_op_clock_a(unit_op_clock_a), .unit_op_clock_b(unit_op_clock_b));

   // 25 MHz clock and gated clock edge counters
   always #20 sys_clk = ~sys_clk;
   always @(posedge periph_clk[7]) e7++;
   always @(posedge periph_clk[4]) e4++;
   always @(posedge periph_clk[1]) e1++;

   task automatic end_of_test();
      if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // One write strobe, released at the edge that takes it
   task automatic wr(input logic [19:0] a, input access_size_t s, input logic [2:0] b,
                     input logic [15:0] d);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_size <= s;
      bus_bit <= b;
      bus_wdata <= d;
      bus_write <= 1'b1;
      @(posedge sys_clk);
      bus_write <= 1'b0;
   endtask : wr

   // Read strobe, data sampled 1 ns after the taking edge
   task automatic rd(input logic [19:0] a, input logic [15:0] e, input string n);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_read <= 1'b1;
      @(posedge sys_clk);
      bus_read <= 1'b0;
      #1 chk(n, e, bus_rdata);
   endtask : rd

   task automatic t_reset();
      chk("gate_port", 16'h0000, {8'h00, peripheral_clock_gate});
      chk("unit_reset", 16'h0003, {14'h0, serial_unit_reset});
      rd(`GATE_ADDR, 16'h0000, "gate_rd");
      rd(`SEL0_ADDR, 16'h0000, "sel0_rd");
      rd(`SEL1_ADDR, 16'h0000, "sel1_rd");
   endtask : t_reset

   task automatic t_locked();
      wr(`SEL0_ADDR, ACC_WORD, 3'h0, 16'h0033);
      rd(`SEL0_ADDR, 16'h0000, "sel0_locked");
      chk("write_ok", 16'h0000, {14'h0, serial_sfr_write_ok});
   endtask : t_locked

   task automatic t_enable();
      wr(`GATE_ADDR, ACC_BYTE, 3'h0, 16'h000e);
      rd(`GATE_ADDR, 16'h000c, "gate_bit1");
      chk("clock_on", 16'h0003, {14'h0, serial_unit_clock_on});
      chk("unit_reset_on", 16'h0000, {14'h0, serial_unit_reset});
      repeat (4) @(posedge sys_clk);
      wr(`SEL0_ADDR, ACC_WORD, 3'h0, 16'ha5c3);
      rd(`SEL0_ADDR, 16'ha5c3, "sel0_word");
      wr(`SEL0_ADDR, ACC_BYTE, 3'h0, 16'hff52);
      rd(`SEL0_ADDR, 16'ha552, "sel0_low");
      wr(`SEL1_ADDR, ACC_WORD, 3'h0, 16'h1234);
      rd(`SEL1_ADDR, 16'h1234, "sel1_word");
   endtask : t_enable

   // Unit 0 codes a=2 b=5, unit 1 codes a=4 b=3, counted over 32 cycles
   task automatic t_ticks();
      int na0, nb0, na1, nb1;
      na0 = 0;
      nb0 = 0;
      na1 = 0;
      nb1 = 0;
      repeat (32) begin
         @(posedge sys_clk);
         #1;
         na0 += unit_op_clock_a[0];
         nb0 += unit_op_clock_b[0];
         na1 += unit_op_clock_a[1];
         nb1 += unit_op_clock_b[1];
      end
      chk("tick_a0", 16'd8, 16'(na0));
      chk("tick_b0", 16'd1, 16'(nb0));
      chk("tick_a1", 16'd2, 16'(na1));
      chk("tick_b1", 16'd4, 16'(nb1));
   endtask : t_ticks

   task automatic t_bits();
      wr(`GATE_ADDR, ACC_BIT, 3'h7, 16'h0001);
      wr(`GATE_ADDR, ACC_BIT, 3'h1, 16'h0001);
      rd(`GATE_ADDR, 16'h008c, "gate_bitwr");
      wr(`SEL1_ADDR, ACC_BIT, 3'h0, 16'h0001);
      rd(`SEL1_ADDR, 16'h1234, "sel1_bitwr");
      rd(20'hf0000, 16'h0000, "unmapped");
      e7 = 0;
      e4 = 0;
      e1 = 0;
      repeat (8) @(posedge sys_clk);
      chk("clk7_runs", 16'h0001, {15'h0, e7 >= 7});
      chk("clk4_stop", 16'h0000, 16'(e4));
      chk("clk1_stop", 16'h0000, 16'(e1));
   endtask : t_bits

   task automatic t_disable();
      wr(`GATE_ADDR, ACC_BIT, 3'h2, 16'h0000);
      #1 chk("unit_reset_off", 16'h0001, {14'h0, serial_unit_reset});
      rd(`SEL0_ADDR, 16'h0000, "sel0_default");
      rd(`SEL1_ADDR, 16'h1234, "sel1_kept");
   endtask : t_disable

   // Watchdog
   initial begin
      #(40 * 3000);
      n_errors++;
      end_of_test();
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_locked();
      t_enable();
      t_ticks();
      t_bits();
      t_disable();
      end_of_test();
   end
endmodule : serial_unit_clock_gate_select_tb
